// >>> tpm_meter.v
`timescale 1ns/1ps
`include "tpm_defines.vh"
module tpm_meter (
    input  wire                 clock,
    input  wire                 sys_rst,
    input  wire                 in_valid,
    output reg                  in_ready,
    input  wire [`TPM_DW-1:0]   in_sample,
    input  wire                 dc_block,
    input  wire                 weight_en,
    output reg  [`TPM_DW-1:0]   peak,
    output reg                  peak_valid
);
    // ****************
    // Helpers
    // ****************
    function signed [`TPM_AW-1:0] sx;
        input signed [`TPM_DW-1:0] v;
        begin
            sx = {{(`TPM_AW-`TPM_DW){v[`TPM_DW-1]}}, v};
        end
    endfunction
    function signed [`TPM_DW-1:0] sat;
        input signed [`TPM_AW-1:0] v;
        begin
            if (v > sx(24'h7fffff)) sat = 24'h7fffff;
            else if (v < sx(24'h800000)) sat = 24'h800000;
            else sat = v[`TPM_DW-1:0];
        end
    endfunction
    // Phases 0 and 1 of the symmetric prototype, Q1.15, unity gain per phase
    // Phases 2 and 3 reuse them reversed, halving the table
    function signed [15:0] coef;
        input [4:0] k;
        begin
            case (k)
                5'h00: coef = 16'h0038;
                5'h01: coef = 16'h0168;
                5'h02: coef = 16'hfd7c;
                5'h03: coef = 16'h0440;
                5'h04: coef = 16'hf864;
                5'h05: coef = 16'h1194;
                5'h06: coef = 16'h7c70;
                5'h07: coef = 16'hf2e8;
                5'h08: coef = 16'h0618;
                5'h09: coef = 16'hfc98;
                5'h0a: coef = 16'h01e8;
                5'h0b: coef = 16'hfef0;
                5'h10: coef = 16'hfc44;
                5'h11: coef = 16'h03c0;
                5'h12: coef = 16'hf960;
                5'h13: coef = 16'h0b68;
                5'h14: coef = 16'heab0;
                5'h15: coef = 16'h3b88;
                5'h16: coef = 16'h63d0;
                5'h17: coef = 16'he65c;
                5'h18: coef = 16'h0d00;
                5'h19: coef = 16'hf88c;
                5'h1a: coef = 16'h043c;
                5'h1b: coef = 16'hfd94;
                default: coef = 16'h0000;
            endcase
        end
    endfunction
    // ****************
    // Input FIFO
    // ****************
    wire                  f_ready;
    wire                  f_valid;
    wire [`TPM_DW-1:0]    f_data;
    reg                   take;
    tpm_fifo #(.WIDTH(`TPM_DW), .DEPTH(`TPM_FIFO_DEPTH), .AW(`TPM_FIFO_AW)) u_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (in_valid),
        .in_ready  (f_ready),
        .in_data   (in_sample),
        .out_valid (f_valid),
        .out_ready (take),
        .out_data  (f_data)
    );
    always @(posedge clock) begin
        if (sys_rst) in_ready <= 1'b0;
        else in_ready <= f_ready;
    end
    // ****************
    // DC blocker and weighting
    // ****************
    reg signed [`TPM_AW-1:0] hp_state;
    reg signed [`TPM_AW-1:0] wt_state;
    reg signed [`TPM_DW-1:0] x_in;
    reg signed [`TPM_DW-1:0] x_hp;
    reg signed [`TPM_DW-1:0] x_w;
    reg signed [`TPM_AW-1:0] next_hp_state;
    reg signed [`TPM_AW-1:0] next_wt_state;
    always @* begin
        x_in          = f_data;
        next_hp_state = hp_state + ((sx(x_in) - hp_state) >>> `TPM_HP_SHIFT);
        // First-order DC tracker subtracted: cheap, corner near fs/1600
        if (dc_block) x_hp = sat(sx(x_in) - hp_state);
        else x_hp = x_in;
        // Simple high-shelf weighting: x + (x - prev)/2, emphasises top band
        next_wt_state = sx(x_hp);
        if (weight_en) x_w = sat(sx(x_hp) + ((sx(x_hp) - wt_state) >>> 1));
        else x_w = x_hp;
    end
    // ****************
    // Polyphase interpolator
    // ****************
    // Zero-stuffed stream seen as four phases of a 12-tap-per-phase branch
    reg signed [`TPM_DW-1:0] hist [0:`TPM_TAPS-1];
    reg [`TPM_PH_W-1:0]      phase;
    reg                      busy;
    reg signed [`TPM_AW-1:0] acc;
    reg [3:0]                ti;
    reg signed [`TPM_AW-1:0] interp;
    reg                      interp_valid;
    integer                  i;
    function [4:0] cidx;
        input [1:0] ph;
        input [3:0] t;
        begin
            // Phase 2,3 are phase 1,0 read backwards (symmetric FIR)
            if (ph[1]) begin
                cidx = {~ph[0], 4'hb - t};
            end else begin
                cidx = {ph[0], t};
            end
        end
    endfunction
    always @* begin
        take = f_valid && !busy;
    end
    wire signed [`TPM_DW-1:0] tap_x = hist[ti];
    wire signed [15:0] tap_c = coef(cidx(phase, ti));
    wire signed [`TPM_AW-1:0] prod = sx(tap_x) * {{(`TPM_AW-16){tap_c[15]}}, tap_c};
    always @(posedge clock) begin
        if (sys_rst) begin
            hp_state     <= `TPM_ZERO_AW;
            wt_state     <= `TPM_ZERO_AW;
            phase        <= 2'h0;
            busy         <= 1'b0;
            acc          <= `TPM_ZERO_AW;
            ti           <= 4'h0;
            interp       <= `TPM_ZERO_AW;
            interp_valid <= 1'b0;
            for (i = 0; i < `TPM_TAPS; i = i + 1) hist[i] <= `TPM_ZERO_DW;
        end else begin
            interp_valid <= 1'b0;
            if (take) begin
                hp_state <= next_hp_state;
                wt_state <= next_wt_state;
                hist[0]  <= x_w;
                for (i = 1; i < `TPM_TAPS; i = i + 1) hist[i] <= hist[i-1];
                busy  <= 1'b1;
                phase <= 2'h0;
                ti    <= 4'h0;
                acc   <= `TPM_ZERO_AW;
            end else if (busy) begin
                // One MAC per cycle: 12 taps x 4 phases fits the sample budget
                if (ti == 4'hb) begin
                    // Zero-stuffing gain of four is already folded into the taps
                    interp       <= (acc + prod) >>> `TPM_CQ;
                    interp_valid <= 1'b1;
                    acc          <= `TPM_ZERO_AW;
                    ti           <= 4'h0;
                    if (phase == `TPM_PH_LAST) busy <= 1'b0;
                    phase <= phase + 2'h1;
                end else begin
                    acc <= acc + prod;
                    ti  <= ti + 4'h1;
                end
            end
        end
    end
    // ****************
    // Peak detector
    // ****************
    reg [`TPM_DW-1:0] mag;
    reg [`TPM_DW-1:0] next_peak;
    always @* begin
        if (interp[`TPM_AW-1]) mag = sat(-interp);
        else mag = sat(interp);
        if (mag > peak) next_peak = mag;
        else next_peak = peak - (peak >> `TPM_DECAY_SHIFT);
    end
    always @(posedge clock) begin
        if (sys_rst) begin
            peak       <= `TPM_ZERO_DW;
            peak_valid <= 1'b0;
        end else begin
            peak_valid <= interp_valid;
            if (interp_valid) peak <= next_peak;
        end
    end
endmodule // tpm_meter

// >>> tpm_defines.vh
`ifndef TPM_DEFINES_VH
`define TPM_DEFINES_VH
// ****************
// Widths and rates
// ****************
`define TPM_DW          24
`define TPM_AW          40
`define TPM_RATIO       4
`define TPM_PH_W        2
`define TPM_PH_LAST     2'h3
`define TPM_TAPS        12
`define TPM_FIFO_DEPTH  4
`define TPM_FIFO_AW     2
// ****************
// Coefficients, Q1.15
// ****************
`define TPM_CQ          15
`define TPM_HP_SHIFT    8
`define TPM_DECAY_SHIFT 12
`define TPM_ZERO_DW     24'h000000
`define TPM_ZERO_AW     40'h0000000000
`endif

// >>> tpm_fifo.v
`timescale 1ns/1ps
// ****************
// Small sample FIFO
// ****************
module tpm_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clock,
    input  wire             sys_rst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output reg              out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            do_wr;
    wire            do_rd;
    assign in_ready = (count != DEPTH[AW:0]);
    assign do_wr    = in_valid && in_ready;
    assign do_rd    = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);
    always @(posedge clock) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_rd) begin
                rd_ptr    <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
                out_data  <= mem[rd_ptr];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            count <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
        end
    end
endmodule // tpm_fifo

// >>> tpm_src.sv
`timescale 1ns/1ps
`include "tpm_defines.vh"
// ****
// Upstream sample source
// ****
module tpm_src (
    input  wire logic              clock,
    input  wire logic              in_ready,
    output logic                   in_valid,
    output logic [`TPM_DW-1:0]     in_sample
);
    initial begin
        in_valid  = 1'b0;
        in_sample = 24'h000000;
    end
    // Two idle edges let the late ready flag catch up, so no word is dropped
    task automatic send(input logic [`TPM_DW-1:0] s);
        @(negedge clock);
        in_valid  = 1'b1;
        in_sample = s;
        do @(posedge clock); while (in_ready !== 1'b1);
        @(negedge clock);
        in_valid  = 1'b0;
        in_sample = ~s;
        @(negedge clock);
    endtask
endmodule // tpm_src

// >>> tpm_meter_chk.sv
`timescale 1ns/1ps
`include "tpm_defines.vh"
// ****
// Port checks
// ****
module tpm_meter_chk (
    input wire logic               clock,
    input wire logic               sys_rst,
    input wire logic               in_valid,
    input wire logic               in_ready,
    input wire logic [`TPM_DW-1:0] peak,
    input wire logic               peak_valid
);
    default clocking @(posedge clock); endclocking
    rst_peak_a:
        assert property (sys_rst |=> peak == 0 && !peak_valid) else $error("peak not cleared");
    rst_ready_a:
        assert property (sys_rst |=> !in_ready) else $error("ready during reset");
    ready_up_a:
        assert property (disable iff (sys_rst) $fell(sys_rst) |-> ##[0:2] in_ready) else $error("ready late");
    peak_hold_a:
        assert property (disable iff (sys_rst) $changed(peak) && !$past(sys_rst) |-> peak_valid)
            else $error("peak moved without valid");
    out_spacing_a:
        assert property (disable iff (sys_rst) peak_valid |=> !peak_valid [*8]) else $error("outputs too close");
    peak_decay_a:
        assert property (disable iff (sys_rst) peak_valid && !$past(sys_rst) |->
            peak >= $past(peak) || peak == $past(peak) - ($past(peak) >> `TPM_DECAY_SHIFT))
            else $error("bad decay step");
    sample_answer_a:
        assert property (disable iff (sys_rst) in_valid && in_ready |-> ##[1:400] peak_valid)
            else $error("no output for sample");
    ready_back_a:
        assert property (disable iff (sys_rst) $fell(in_ready) |-> ##[1:200] in_ready) else $error("fifo stuck");
    cover property (peak_valid);
    cover property (disable iff (sys_rst) $fell(in_ready));
    cover property (disable iff (sys_rst) peak_valid && peak < $past(peak));
endmodule // tpm_meter_chk
bind tpm_meter tpm_meter_chk chk_u (.clock(clock), .sys_rst(sys_rst), .in_valid(in_valid),
    .in_ready(in_ready), .peak(peak), .peak_valid(peak_valid));

// >>> tb_top.sv
`timescale 1ns/1ps
`include "tpm_defines.vh"
// ****
// Meter bench
// ****
module tb_top;
    logic               clock = 1'b0;
    logic               sys_rst;
    logic               dc_block;
    logic               weight_en;
    wire                in_valid, in_ready, peak_valid;
    wire [`TPM_DW-1:0]  in_sample, peak;
    integer             miscompares = 0, samples_checked = 0, n_pv = 0;
    always #25 clock = ~clock;
    always @(posedge clock) if (peak_valid === 1'b1) n_pv <= n_pv + 1;
    tpm_meter dut_u (.clock(clock), .sys_rst(sys_rst), .in_valid(in_valid), .in_ready(in_ready),
        .in_sample(in_sample), .dc_block(dc_block), .weight_en(weight_en), .peak(peak), .peak_valid(peak_valid));
    tpm_src src_u (.clock(clock), .in_ready(in_ready), .in_valid(in_valid), .in_sample(in_sample));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_of_test;
        if (miscompares == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task rst;
        @(negedge clock) sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        n_pv = 0;
    endtask
    // Covers the worst queue: five waiting words (four in the FIFO, one in its output register) at one per ~49 cycles
    task settle;
        repeat (400) @(negedge clock);
    endtask
    task t_reset;
        rst;
        chk("peak", peak, 0);
        chk("peak_valid", peak_valid, 0);
    endtask
    task t_dc;
        dc_block = 1'b0;
        rst;
        repeat (12) src_u.send(24'h200000);
        settle;
        chk("dc peak", peak > 24'h1c0000 && peak < 24'h240000, 1);
        chk("outputs", n_pv, 48);
    endtask
    // Tone at a quarter rate, sampled 45 degrees off its crests
    task t_tone(input logic w, input logic d);
        logic [`TPM_DW-1:0] pk;
        weight_en = w;
        dc_block = d;
        rst;
        repeat (6) begin
            src_u.send(24'h200000);
            src_u.send(24'h200000);
            src_u.send(24'he00000);
            src_u.send(24'he00000);
        end
        settle;
        pk = peak;
        chk("true peak", peak > 24'h280000, 1);
        if (!w) chk("peak ceiling", peak < 24'h300000, 1);
        repeat (20) src_u.send(24'h000000);
        settle;
        chk("decay", peak < pk && peak > pk - (pk >> 3), 1);
        chk("outputs", n_pv, 176);
    endtask
    initial begin
        #1000000;
        miscompares++;
        end_of_test;
    end
    initial begin
        sys_rst = 1'b1;
        dc_block = 1'b0;
        weight_en = 1'b0;
        t_reset;
        t_dc;
        t_tone(1'b0, 1'b0);
        t_tone(1'b1, 1'b0);
        t_tone(1'b0, 1'b1);
        end_of_test;
    end
endmodule // tb_top
